/* File: design/smc_pkg.sv */
// Constants, types and behaviour list of the sleep mode controller.
// Behaviour
// - Sleep only when armed at instruction time
// - Select 00: idle, core and flash clocks stop
// - Select 01: noise reduction, io clock stops
// - Select 10: power-down, all clocks stop
// - Select 11: power-save, async clock runs
// - Interrupt wake: core halted four extra cycles
// - Register file and memory kept across sleep
// - Reset during sleep restarts at reset vector
// - Idle: every enabled interrupt wakes core
// - Noise reduction: only listed sources wake
// - Power-down: only listed sources wake
// - Deep modes: external irqs wake only level-sensitive
// - Idle or noise reduction starts conversion
// - Power-down wake waits fuse-selected restart delay
// - Power-save: async timer0 irq wakes if enabled
// - Timer0 undefined after power-save without async
// - Brownout software disable only in deep modes
// - Brownout off at entry, back on wake
// - Brownout-off wake takes about 60 us
// - Brownout sleep off resets to zero
// - Off bit set only by timed unlock
// - Off bit effective after three, clears after
package smc_pkg;

  // Register byte offsets.
  localparam logic [7:0] SLEEP_CTRL_OFS = 8'h00;
  localparam logic [7:0] CORE_CTRL_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS     = 8'h08;

  // Field positions.
  localparam int ARM_POS      = 0;
  localparam int SEL_LO_POS   = 1;
  localparam int SEL_HI_POS   = 2;
  localparam int UNLOCK_POS   = 5;
  localparam int SLP_OFF_POS  = 6;
  localparam int ST_ASLEEP    = 0;
  localparam int ST_BO_OFF    = 1;
  localparam int ST_T0_UNDEF  = 2;
  localparam int ST_MODE_LO   = 4;

  // Reset values.
  localparam logic       ARM_RST     = 1'b0;
  localparam logic [1:0] SEL_RST     = 2'h0;
  localparam logic       SLP_OFF_RST = 1'b0;

  // Timing.
  localparam int CLK_NS           = 20;
  localparam int HALT_CYC         = 4;
  localparam int UNLOCK_CYC       = 4;
  localparam int OFF_DELAY_CYC    = 3;
  localparam int OFF_LIFE_CYC     = 3;
  localparam int BO_WAKE_NS       = 60000;
  localparam int BO_WAKE_CYC      = (BO_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESTART_UNIT_CYC = 16;

  // Wake source index in the wake vector.
  localparam int WK_XIRQ0 = 0;
  localparam int WK_XIRQ1 = 1;
  localparam int WK_PCHG  = 2;
  localparam int WK_WDOG  = 3;
  localparam int WK_USER  = 4;
  localparam int WK_PROG  = 5;
  localparam int WK_CONV  = 6;
  localparam int WK_TMR0  = 7;
  localparam int WK_IO    = 8;
  localparam int WK_NUM   = 9;

  typedef enum logic [1:0] {M_IDLE, M_CONV, M_PDOWN, M_PSAVE} smc_mode_e;
  typedef enum {S_RUN, S_SLEEP, S_RESTART, S_HALT} smc_state_e;

endpackage : smc_pkg

/* File: design/smc_top.sv */
// Sleep mode controller: clock gating, wake filter, brownout sleep control.
`timescale 1ns/10ps
`default_nettype none
module smc_top (
  // Clock and reset.
  input  wire logic        MCLK_I,
  input  wire logic        RESETN_I,
  // Wishbone slave.
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Core handshake.
  input  wire logic        SLEEP_EXEC_I,
  input  wire logic        GLOBAL_IRQ_EN_I,
  output logic             CORE_HALT_O,
  output logic             WAKE_IRQ_O,
  // Wake sources, asynchronous.
  input  wire logic [8:0]  WAKE_SRC_I,
  // Configuration from peripherals and fuses.
  input  wire logic        XIRQ0_LEVEL_I,
  input  wire logic        XIRQ1_LEVEL_I,
  input  wire logic        TIMER0_ASYNC_SELECT_I,
  input  wire logic        TIMER0_IRQ_MASK_I,
  input  wire logic        CONV_ENABLE_I,
  input  wire logic [3:0]  CLOCK_SELECT_FUSES_I,
  // Clock and analog enables.
  output logic             CORE_CLK_EN_O,
  output logic             FLASH_CLK_EN_O,
  output logic             IO_CLK_EN_O,
  output logic             CONV_CLK_EN_O,
  output logic             ASYNC_CLK_EN_O,
  output logic             MAIN_OSC_EN_O,
  output logic             TIMER0_OSC_EN_O,
  output logic             BROWNOUT_EN_O,
  output logic             CONV_START_O,
  output logic             TIMER0_UNDEF_O
);

  smc_pkg::smc_state_e st;
  smc_pkg::smc_mode_e  md;
  logic                arm;
  logic [1:0]          sel;
  logic                slp_off;
  logic [2:0]          off_cnt;
  logic [2:0]          unl_cnt;
  logic                bo_off;
  logic                t0_undef;
  logic [11:0]         cnt;
  logic [8:0]          wk;
  logic [8:0]          wk_ok;
  logic                wake;
  logic                off_eff;
  logic                wr, rd_hit;
  logic [31:0]         rdat;
  logic [11:0]         restart_cyc;

  // Bus write lands on the edge where the master sees ack high.
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0];

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
      WB_DAT_O <= rd_hit ? rdat : 32'h0000_0000;
    end
  end

  always_comb begin
    rdat   = 32'h0000_0000;
    rd_hit = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
    case (WB_ADR_I)
      smc_pkg::SLEEP_CTRL_OFS: begin
        rdat[smc_pkg::ARM_POS]                           = arm;
        rdat[smc_pkg::SEL_HI_POS:smc_pkg::SEL_LO_POS]    = sel;
      end
      smc_pkg::CORE_CTRL_OFS: begin
        rdat[smc_pkg::SLP_OFF_POS] = slp_off;
      end
      smc_pkg::STATUS_OFS: begin
        rdat[smc_pkg::ST_ASLEEP]                          = CORE_HALT_O;
        rdat[smc_pkg::ST_BO_OFF]                          = bo_off;
        rdat[smc_pkg::ST_T0_UNDEF]                        = t0_undef;
        rdat[smc_pkg::ST_MODE_LO+1:smc_pkg::ST_MODE_LO]   = md;
      end
      default: rdat = 32'h0000_0000;
    endcase
  end

  // Sleep control register.
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      arm <= smc_pkg::ARM_RST;
      sel <= smc_pkg::SEL_RST;
    end else if (wr && WB_ADR_I == smc_pkg::SLEEP_CTRL_OFS) begin
      arm <= WB_DAT_I[smc_pkg::ARM_POS];
      sel <= WB_DAT_I[smc_pkg::SEL_HI_POS:smc_pkg::SEL_LO_POS];
    end
  end

  // Timed unlock: both bits one opens a short window for the real write.
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      unl_cnt <= 3'h0;
      slp_off <= smc_pkg::SLP_OFF_RST;
      off_cnt <= 3'h0;
    end else begin
      if (wr && WB_ADR_I == smc_pkg::CORE_CTRL_OFS && WB_DAT_I[smc_pkg::SLP_OFF_POS]
          && WB_DAT_I[smc_pkg::UNLOCK_POS]) begin
        unl_cnt <= 3'(smc_pkg::UNLOCK_CYC);
      end else if (unl_cnt != 3'h0) begin
        unl_cnt <= unl_cnt - 3'h1;
      end
      if (wr && WB_ADR_I == smc_pkg::CORE_CTRL_OFS && WB_DAT_I[smc_pkg::SLP_OFF_POS]
          && !WB_DAT_I[smc_pkg::UNLOCK_POS] && unl_cnt != 3'h0 && !slp_off) begin
        slp_off <= 1'b1;
        off_cnt <= 3'h0;
      end else if (slp_off) begin
        off_cnt <= off_cnt + 3'h1;
        if (off_cnt == 3'(smc_pkg::OFF_DELAY_CYC + smc_pkg::OFF_LIFE_CYC - 1)) begin
          slp_off <= 1'b0;
        end
      end
    end
  end

  // The bit is only honoured after its settling delay.
  assign off_eff = slp_off && off_cnt >= 3'(smc_pkg::OFF_DELAY_CYC);

  // Three-stage filter; a source counts once stages two and three agree, so
  // a glitch shorter than one clock, sampled by at most one edge, never wakes the core.
  genvar gi;
  generate
    for (gi = 0; gi < smc_pkg::WK_NUM; gi++) begin : g_sync
      // Each source keeps its own stages, so every flop has a single writer.
      logic s1;
      logic s2;
      logic s3;
      logic agreed;
      always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          s1     <= 1'b0;
          s2     <= 1'b0;
          s3     <= 1'b0;
          agreed <= 1'b0;
        end else begin
          s1 <= WAKE_SRC_I[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            agreed <= s3;
          end
        end
      end
      assign wk[gi] = agreed;
    end
  endgenerate

  // Wake permission per mode.
  always_comb begin
    wk_ok = 9'h000;
    case (md)
      smc_pkg::M_IDLE: wk_ok = 9'h1FF;
      smc_pkg::M_CONV: begin
        wk_ok = 9'h0FC;
      end
      smc_pkg::M_PDOWN: begin
        wk_ok = 9'h01C;
      end
      smc_pkg::M_PSAVE: begin
        wk_ok = 9'h01C;
        wk_ok[smc_pkg::WK_TMR0] = TIMER0_ASYNC_SELECT_I && TIMER0_IRQ_MASK_I && GLOBAL_IRQ_EN_I;
      end
      default: wk_ok = 9'h000;
    endcase
    if (md != smc_pkg::M_IDLE) begin
      wk_ok[smc_pkg::WK_XIRQ0] = XIRQ0_LEVEL_I;
      wk_ok[smc_pkg::WK_XIRQ1] = XIRQ1_LEVEL_I;
    end
  end

  assign wake = |(wk & wk_ok);

  // Deep modes restart the oscillator for a fuse-scaled time.
  assign restart_cyc = 12'(smc_pkg::RESTART_UNIT_CYC) << CLOCK_SELECT_FUSES_I[1:0];

  // Sleep sequencer. Memories are only clock gated, never cleared.
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st       <= smc_pkg::S_RUN;
      md       <= smc_pkg::M_IDLE;
      bo_off   <= 1'b0;
      cnt      <= 12'h000;
      t0_undef <= 1'b0;
    end else begin
      case (st)
        smc_pkg::S_RUN: begin
          if (SLEEP_EXEC_I && arm) begin
            st     <= smc_pkg::S_SLEEP;
            md     <= smc_pkg::smc_mode_e'(sel);
            bo_off <= off_eff && sel[1];
          end
        end
        smc_pkg::S_SLEEP: begin
          if (wake) begin
            st  <= smc_pkg::S_RESTART;
            cnt <= bo_off ? 12'(smc_pkg::BO_WAKE_CYC) :
                   (md[1] ? restart_cyc : 12'h001);
            if (md == smc_pkg::M_PSAVE && !TIMER0_ASYNC_SELECT_I) begin
              t0_undef <= 1'b1;
            end
          end
        end
        smc_pkg::S_RESTART: begin
          bo_off <= 1'b0;
          if (cnt <= 12'h001) begin
            st  <= smc_pkg::S_HALT;
            cnt <= 12'(smc_pkg::HALT_CYC);
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        smc_pkg::S_HALT: begin
          if (cnt <= 12'h001) begin
            st <= smc_pkg::S_RUN;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        default: st <= smc_pkg::S_RUN;
      endcase
      if (wr && WB_ADR_I == smc_pkg::STATUS_OFS && WB_DAT_I[smc_pkg::ST_T0_UNDEF]
          && !(st == smc_pkg::S_SLEEP && wake && md == smc_pkg::M_PSAVE)) begin
        t0_undef <= 1'b0;
      end
    end
  end

  // Registered enables, derived from the sequencer state.
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CORE_CLK_EN_O   <= 1'b1;
      FLASH_CLK_EN_O  <= 1'b1;
      IO_CLK_EN_O     <= 1'b1;
      CONV_CLK_EN_O   <= 1'b1;
      ASYNC_CLK_EN_O  <= 1'b1;
      MAIN_OSC_EN_O   <= 1'b1;
      TIMER0_OSC_EN_O <= 1'b1;
      BROWNOUT_EN_O   <= 1'b1;
      CORE_HALT_O     <= 1'b0;
      WAKE_IRQ_O      <= 1'b0;
      CONV_START_O    <= 1'b0;
      TIMER0_UNDEF_O  <= 1'b0;
    end else begin
      CORE_CLK_EN_O   <= st == smc_pkg::S_RUN;
      FLASH_CLK_EN_O  <= st == smc_pkg::S_RUN;
      IO_CLK_EN_O     <= st == smc_pkg::S_RUN || st == smc_pkg::S_HALT
                         || md == smc_pkg::M_IDLE;
      CONV_CLK_EN_O   <= st == smc_pkg::S_RUN || st == smc_pkg::S_HALT || !md[1];
      ASYNC_CLK_EN_O  <= st == smc_pkg::S_RUN || st == smc_pkg::S_HALT
                         || md != smc_pkg::M_PDOWN;
      MAIN_OSC_EN_O   <= st != smc_pkg::S_SLEEP || !md[1];
      TIMER0_OSC_EN_O <= st != smc_pkg::S_SLEEP || md != smc_pkg::M_PDOWN;
      BROWNOUT_EN_O   <= !(st == smc_pkg::S_SLEEP && bo_off);
      CORE_HALT_O     <= st != smc_pkg::S_RUN;
      WAKE_IRQ_O      <= st == smc_pkg::S_HALT && cnt <= 12'h001;
      CONV_START_O    <= st == smc_pkg::S_RUN && SLEEP_EXEC_I && arm && !sel[1]
                         && CONV_ENABLE_I;
      TIMER0_UNDEF_O  <= t0_undef;
    end
  end

  // Checks.
  logic in_halt_new;
  assign in_halt_new = st == smc_pkg::S_HALT && cnt == 12'(smc_pkg::HALT_CYC);

  a_unarmed_stays: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_RUN && SLEEP_EXEC_I && !arm |=> st == smc_pkg::S_RUN ##1 !CORE_HALT_O)
    else $error("unarmed sleep changed state");
  a_armed_enters: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_RUN && SLEEP_EXEC_I && arm |=> st == smc_pkg::S_SLEEP ##1 CORE_HALT_O)
    else $error("armed sleep not entered");
  a_idle_clocks: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_SLEEP && md == smc_pkg::M_IDLE |=> !CORE_CLK_EN_O && IO_CLK_EN_O && CONV_CLK_EN_O)
    else $error("idle clocks wrong");
  a_conv_clocks: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_SLEEP && md == smc_pkg::M_CONV |=> !IO_CLK_EN_O && CONV_CLK_EN_O && MAIN_OSC_EN_O)
    else $error("noise reduction clocks wrong");
  a_deep_clocks: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_SLEEP && md[1] |=> !CONV_CLK_EN_O && !MAIN_OSC_EN_O && ASYNC_CLK_EN_O == md[0])
    else $error("deep sleep clocks wrong");
  a_halt_four: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    in_halt_new |-> (st == smc_pkg::S_HALT)[*4] ##1 st == smc_pkg::S_RUN && WAKE_IRQ_O)
    else $error("halt length not four");
  a_edge_no_wake: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_SLEEP && md != smc_pkg::M_IDLE && !XIRQ0_LEVEL_I && !XIRQ1_LEVEL_I
    && (wk & ~9'h003) == 9'h000 |=> st == smc_pkg::S_SLEEP)
    else $error("edge irq woke deep sleep");
  a_conv_start: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_RUN && SLEEP_EXEC_I && arm && sel == 2'h1 && CONV_ENABLE_I |=> CONV_START_O)
    else $error("conversion not started");
  a_bo_shallow_on: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_SLEEP && !md[1] |=> BROWNOUT_EN_O)
    else $error("brownout off in shallow sleep");
  a_bo_wake_long: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_SLEEP && wake && bo_off |=> (st == smc_pkg::S_RESTART)[*8])
    else $error("brownout wake too short");
  a_off_locked: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    !slp_off && unl_cnt == 3'h0 && !(wr && WB_DAT_I[smc_pkg::UNLOCK_POS]) |=> !slp_off)
    else $error("off bit set without unlock");
  a_off_expires: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    $rose(slp_off) |-> !off_eff[*3] ##1 off_eff[*3] ##1 !slp_off)
    else $error("off bit timing wrong");

  c_idle_wake: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_SLEEP && md == smc_pkg::M_IDLE ##1 st == smc_pkg::S_RESTART);
  c_pdown_wake: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_SLEEP && md == smc_pkg::M_PDOWN ##1 st == smc_pkg::S_RESTART);
  c_psave_timer: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_SLEEP && md == smc_pkg::M_PSAVE && wk[smc_pkg::WK_TMR0]);
  c_bo_off_sleep: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    st == smc_pkg::S_SLEEP && !BROWNOUT_EN_O);

endmodule : smc_top
`default_nettype wire

/* File: dv/smc_core_model.sv */
// Core-side model: issues sleep instructions and holds interrupt requests.
`timescale 1ns/10ps
`default_nettype none
module smc_core_model (
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // Requests from the bench.
  input  wire logic       sleep_req_i,
  input  wire logic [8:0] raise_i,
  // Controller side.
  input  wire logic       wake_irq_i,
  output logic            sleep_exec_o,
  output logic      [8:0] wake_src_o
);
  logic handled;
  // The bench arms the controller before it asks for the instruction.
  assign sleep_exec_o = sleep_req_i;
  // A request stays up until its handler runs, so no short glitch is relied on.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      handled    <= 1'h0;
      wake_src_o <= 9'h000;
    end else begin
      handled    <= wake_irq_i | (handled & (|raise_i));
      wake_src_o <= (handled | wake_irq_i) ? 9'h000 : raise_i;
    end
  end
endmodule // smc_core_model
`default_nettype wire

/* File: dv/smc_testbench.sv */
// Self-checking bench for the sleep mode controller.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        cyc = 1'h0, stb = 1'h0, we = 1'h0, sreq = 1'h0, gie = 1'h1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, dat_o;
  logic [8:0]  raise = 9'h000, wsrc;
  logic        lvl0 = 1'h0, t0as = 1'h0, t0m = 1'h1, cen = 1'h1;
  logic [3:0]  fuse = 4'h1;
  logic [7:0]  en;
  logic        ack, halt, wirq, sexec, cstart, t0u;
  int          fail_count = 0, n_checks = 0, conv_n = 0;
  localparam int ID_LO = smc_pkg::HALT_CYC + 2;
  localparam int ID_HI = 25;
  localparam int PD_LO = (smc_pkg::RESTART_UNIT_CYC << 1) + smc_pkg::HALT_CYC;
  localparam int PD_HI = (smc_pkg::RESTART_UNIT_CYC << 1) + 25;
  localparam int BO_LO = smc_pkg::BO_WAKE_CYC;
  localparam int BO_HI = smc_pkg::BO_WAKE_CYC + 25;

  always #10 clk = ~clk;
  always @(posedge clk) if (cstart === 1'h1) conv_n <= conv_n + 1;

  smc_top u_dut (
    .MCLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .SLEEP_EXEC_I(sexec), .GLOBAL_IRQ_EN_I(gie), .CORE_HALT_O(halt), .WAKE_IRQ_O(wirq),
    .WAKE_SRC_I(wsrc), .XIRQ0_LEVEL_I(lvl0), .XIRQ1_LEVEL_I(lvl0),
    .TIMER0_ASYNC_SELECT_I(t0as), .TIMER0_IRQ_MASK_I(t0m), .CONV_ENABLE_I(cen),
    .CLOCK_SELECT_FUSES_I(fuse), .CORE_CLK_EN_O(en[7]), .FLASH_CLK_EN_O(en[6]),
    .IO_CLK_EN_O(en[5]), .CONV_CLK_EN_O(en[4]), .ASYNC_CLK_EN_O(en[3]), .MAIN_OSC_EN_O(en[2]),
    .TIMER0_OSC_EN_O(en[1]), .BROWNOUT_EN_O(en[0]), .CONV_START_O(cstart), .TIMER0_UNDEF_O(t0u)
  );

  smc_core_model u_core (
    .mclk_i(clk), .resetn_i(rst_n), .sleep_req_i(sreq), .raise_i(raise),
    .wake_irq_i(wirq), .sleep_exec_o(sexec), .wake_src_o(wsrc)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Classic single cycle; the gap cycle afterwards keeps requests apart.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'h1 && i < 50);
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (i >= 50) begin
      fail_count++;
      final_report();
    end
    @(posedge clk);
  endtask

  // Sleep in mode m, offer sources that must not wake, then one that must.
  task automatic do_sleep(input logic [1:0] m, input int brownout_sleep_off, input logic [8:0] bad,
                          input logic [8:0] good, input logic [7:0] exp_en, input int lo, input int hi);
    logic [31:0] q;
    int c0, n;
    wb(1'h1, 8'h00, {29'h0, m, 1'h1}, q);
    if (brownout_sleep_off != 0) begin
      if (brownout_sleep_off == 1) wb(1'h1, 8'h04, 32'h60, q);
      wb(1'h1, 8'h04, 32'h40, q);
      repeat (2) @(posedge clk);
    end
    c0 = conv_n;
    sreq <= 1'h1;
    @(posedge clk);
    sreq <= 1'h0;
    repeat (4) @(posedge clk);
    check(en, exp_en);
    check(conv_n - c0, (m < 2 && cen) ? 1 : 0);
    if (bad != 9'h000) begin
      raise <= bad;
      repeat (60) @(posedge clk);
      check(halt, 1'h1);
      raise <= 9'h000;
      repeat (2) @(posedge clk);
    end
    raise <= good;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wirq !== 1'h1 && n < hi + 50);
    raise <= 9'h000;
    check(n >= lo && n <= hi, 1'h1);
    // Core and flash clocks come back one cycle after the wake pulse.
    check(en, 8'h3F);
    @(posedge clk);
    check(en, 8'hFF);
    check({halt, wirq}, 2'h0);
    if (n >= hi + 50) final_report();
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    wb(1'h0, 8'h00, 32'h0, q);
    check(q, 32'h0);
    wb(1'h0, 8'h04, 32'h0, q);
    check(q, 32'h0);
    wb(1'h0, 8'h0C, 32'h0, q);
    check(q, 32'h0);
    check({en, halt}, 9'h1FE);
    $display("test reset done");
  endtask

  task automatic t_unarmed();
    logic [31:0] q;
    wb(1'h1, 8'h00, 32'h4, q);
    sreq <= 1'h1;
    @(posedge clk);
    sreq <= 1'h0;
    repeat (4) @(posedge clk);
    check({en, halt, wirq}, 10'h3FC);
    $display("test unarmed done");
  endtask

  task automatic t_modes();
    do_sleep(2'h0, 0, 9'h000, 9'h100, 8'h3F, ID_LO, ID_HI);
    do_sleep(2'h1, 0, 9'h100, 9'h040, 8'h1F, ID_LO, ID_HI);
    do_sleep(2'h2, 0, 9'h1E0, 9'h010, 8'h01, PD_LO, PD_HI);
    t0as <= 1'h1;
    do_sleep(2'h3, 0, 9'h160, 9'h080, 8'h0B, PD_LO, PD_HI);
    $display("test modes done");
  endtask

  task automatic t_filter();
    logic [31:0] q;
    do_sleep(2'h2, 0, 9'h003, 9'h004, 8'h01, PD_LO, PD_HI);
    do_sleep(2'h0, 0, 9'h000, 9'h002, 8'h3F, ID_LO, ID_HI);
    lvl0 <= 1'h1;
    do_sleep(2'h1, 0, 9'h000, 9'h001, 8'h1F, ID_LO, ID_HI);
    t0m <= 1'h0;
    do_sleep(2'h3, 0, 9'h080, 9'h008, 8'h0B, PD_LO, PD_HI);
    t0as <= 1'h0;
    t0m <= 1'h1;
    do_sleep(2'h3, 0, 9'h000, 9'h008, 8'h0B, PD_LO, PD_HI);
    check(t0u, 1'h1);
    wb(1'h0, 8'h08, 32'h0, q);
    check(q, 32'h34);
    wb(1'h1, 8'h08, 32'h4, q);
    wb(1'h0, 8'h08, 32'h0, q);
    check(q, 32'h30);
    check(t0u, 1'h0);
    $display("test filter done");
  endtask

  task automatic t_brownout();
    do_sleep(2'h2, 1, 9'h000, 9'h008, 8'h00, BO_LO, BO_HI);
    do_sleep(2'h0, 1, 9'h000, 9'h008, 8'h3F, ID_LO, ID_HI);
    do_sleep(2'h2, 2, 9'h000, 9'h008, 8'h01, PD_LO, PD_HI);
    $display("test brownout done");
  endtask

  // An asynchronous reset in deep sleep must restart without a wake interrupt.
  task automatic t_sleep_reset();
    logic [31:0] q;
    wb(1'h1, 8'h00, 32'h5, q);
    sreq <= 1'h1;
    @(posedge clk);
    sreq <= 1'h0;
    repeat (4) @(posedge clk);
    check(halt, 1'h1);
    rst_n <= 1'h0;
    @(posedge clk);
    check({en, halt, wirq}, 10'h3FC);
    rst_n <= 1'h1;
    @(posedge clk);
    wb(1'h0, 8'h00, 32'h0, q);
    check(q, 32'h0);
    $display("test sleep reset done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_unarmed();
    t_modes();
    t_filter();
    t_brownout();
    t_sleep_reset();
    final_report();
  end
endmodule // testbench
`default_nettype wire
